// ===== rtl/bfs_pkg.sv
// shared constants and types for the bit, flag and shift execution block
package bfs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PC = 8'h08;
  localparam logic [7:0] OFF_RF_SEL = 8'h0C;
  localparam logic [7:0] OFF_RF_DATA = 8'h10;
  localparam logic [7:0] OFF_IO_SEL = 8'h14;
  localparam logic [7:0] OFF_IO_DATA = 8'h18;

  // ----------------------------------------------------------------
  // command word fields and the status busy bit position
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 6;
  localparam int CMD_DST_LSB = 9;
  localparam int CMD_SRC_LSB = 14;
  localparam int CMD_IMM_LSB = 19;
  localparam int STATUS_BUSY_BIT = 8;

  // ----------------------------------------------------------------
  // status flag positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_S = 4;
  localparam int FLG_H = 5;
  localparam int FLG_T = 6;
  localparam int FLG_I = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] RF_RST = 8'h00;
  localparam logic [7:0] IO_RST = 8'h00;

  // ----------------------------------------------------------------
  // operations, states, shift kinds
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BRANCH_WHEN_IRQ_ON = 6'h01,
    OP_BRANCH_WHEN_IRQ_OFF = 6'h02,
    OP_IO_BIT_RAISE = 6'h03,
    OP_IO_BIT_DROP = 6'h04,
    OP_LOGIC_SHIFT_LEFT = 6'h05,
    OP_LOGIC_SHIFT_RIGHT = 6'h06,
    OP_ROTATE_LEFT_CARRY = 6'h07,
    OP_ROTATE_RIGHT_CARRY = 6'h08,
    OP_ARITH_SHIFT_RIGHT = 6'h09,
    OP_NIBBLE_SWAP = 6'h0A,
    OP_FLAG_RAISE = 6'h0B,
    OP_FLAG_DROP = 6'h0C,
    OP_COPY_BIT_TO_TRANSFER_FLAG = 6'h0D,
    OP_LOAD_BIT_FROM_TRANSFER = 6'h0E,
    OP_COPY_REGISTER = 6'h0F,
    OP_COPY_REGISTER_PAIR = 6'h10,
    OP_LOAD_IMMEDIATE = 6'h11
  } bfs_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SECOND = 2'b11
  } bfs_state_t;

  typedef enum logic [2:0] {
    SH_LOGIC_SHIFT_LEFT = 3'h0,
    SH_LOGIC_SHIFT_RIGHT = 3'h1,
    SH_ROTATE_LEFT_CARRY = 3'h2,
    SH_ROTATE_RIGHT_CARRY = 3'h3,
    SH_ARITH_SHIFT_RIGHT = 3'h4
  } bfs_shift_t;

endpackage

// ===== rtl/bfs_shift_if.sv
// bundle between the execution core and its shift unit
`timescale 1ns/1ps
`default_nettype none
interface bfs_shift_if;
  bfs_pkg::bfs_shift_t kind;
  logic [7:0] operand;
  logic carry_in;
  logic [7:0] result;
  logic c_out;
  logic z_out;
  logic n_out;
  logic v_out;

  modport core(output kind, output operand, output carry_in,
               input result, input c_out, input z_out, input n_out, input v_out);
  modport unit(input kind, input operand, input carry_in,
               output result, output c_out, output z_out, output n_out, output v_out);
endinterface
`default_nettype wire

// ===== rtl/bfs_shift_unit.sv
// shift and rotate unit with zero, carry, negative and overflow results
`timescale 1ns/1ps
`default_nettype none
module bfs_shift_unit (
  bfs_shift_if.unit sh
);
  always_comb begin
    sh.result = sh.operand;
    sh.c_out = 1'b0;
    unique case (sh.kind)
      bfs_pkg::SH_LOGIC_SHIFT_LEFT: begin
        sh.result = {sh.operand[6:0], 1'b0};
        sh.c_out = sh.operand[7];
      end
      bfs_pkg::SH_ROTATE_LEFT_CARRY: begin
        sh.result = {sh.operand[6:0], sh.carry_in};
        sh.c_out = sh.operand[7];
      end
      bfs_pkg::SH_LOGIC_SHIFT_RIGHT: begin
        sh.result = {1'b0, sh.operand[7:1]};
        sh.c_out = sh.operand[0];
      end
      bfs_pkg::SH_ROTATE_RIGHT_CARRY: begin
        sh.result = {sh.carry_in, sh.operand[7:1]};
        sh.c_out = sh.operand[0];
      end
      bfs_pkg::SH_ARITH_SHIFT_RIGHT: begin
        sh.result = {sh.operand[7], sh.operand[7:1]};
        sh.c_out = sh.operand[0];
      end
      default: begin
        sh.result = sh.operand;
        sh.c_out = 1'b0;
      end
    endcase
  end

  // overflow is negative xor carry, as for any single-place shift
  assign sh.z_out = (sh.result == 8'h00);
  assign sh.n_out = sh.result[7];
  assign sh.v_out = sh.result[7] ^ sh.c_out;
endmodule
`default_nettype wire

// ===== rtl/bfs_exec_core.sv
// execution core for branch-on-interrupt-flag, bit, flag, shift and move operations
//
// Summary of operation
// - With the global interrupt flag set, the branch-when-on op adds offset plus one to pc, one cycle not taken, two taken.
// - With the global interrupt flag clear, the branch-when-off op adds offset plus one to pc, one cycle not taken, two taken.
// - The io bit raise op sets the chosen bit of the addressed io register in two cycles, flags untouched.
// - The io bit drop op clears the chosen bit of the addressed io register in two cycles, flags untouched.
// - Left shift and left rotate move bits up in one cycle, feeding zero or old carry into bit 0, bit 7 to carry, updating Z C N V.
// - Right rotate, logical and arithmetic right shift move bits down in one cycle, bit 0 to carry, updating Z C N V.
// - Bit copy to the transfer flag takes the chosen source bit into T only, in one cycle.
// - Bit load from the transfer flag writes T into the chosen destination bit in one cycle, flags untouched.
// - Each flag raise op sets only its own status flag in one cycle.
// - Each flag drop op clears only its own status flag in one cycle.
`timescale 1ns/1ps
`default_nettype none
module bfs_exec_core #(
  parameter int IO_REGS = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] io_port0
);
  localparam int IOW = (IO_REGS > 1) ? $clog2(IO_REGS) : 1;

  // io address comes from an 8-bit immediate, so more than 256 entries are unreachable
  if (IO_REGS < 1 || IO_REGS > 256) begin : g_bad_io_regs
    $error("IO_REGS must lie in 1..256");
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] rf [0:31];
  logic [7:0] io_mem [0:IO_REGS-1];
  logic [7:0] status_flags_reg;
  logic [15:0] pc;
  logic [4:0] rf_sel;
  logic [IOW-1:0] io_sel;
  bfs_pkg::bfs_state_t state;
  bfs_pkg::bfs_state_t next_state;
  logic idle_q;

  // latched command
  bfs_pkg::bfs_op_t op;
  logic [2:0] bsel;
  logic [4:0] dst;
  logic [4:0] src;
  logic [7:0] imm;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic idle;
  logic mapped;
  logic access;
  logic wr_fire;

  assign idle = (state == bfs_pkg::ST_IDLE);
  assign access = psel && penable;
  always_comb begin
    unique case (paddr)
      bfs_pkg::OFF_CMD, bfs_pkg::OFF_STATUS, bfs_pkg::OFF_PC, bfs_pkg::OFF_RF_SEL,
      bfs_pkg::OFF_RF_DATA, bfs_pkg::OFF_IO_SEL, bfs_pkg::OFF_IO_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // any access waits while an op runs, and one more cycle so read data is fresh
  assign pready = access && idle && idle_q;
  assign pslverr = pready && !mapped;
  assign wr_fire = pready && pwrite && mapped;

  function automatic logic wr_to(input logic [7:0] off);
    wr_to = wr_fire && (paddr == off);
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_q <= 1'b0;
    end else begin
      idle_q <= idle;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !pwrite) begin
      unique case (paddr)
        bfs_pkg::OFF_CMD: prdata <= {5'h00, imm, src, dst, bsel, op};
        bfs_pkg::OFF_STATUS: prdata <= {23'h00_0000, !idle, status_flags_reg};
        bfs_pkg::OFF_PC: prdata <= {16'h0000, pc};
        bfs_pkg::OFF_RF_SEL: prdata <= {27'h000_0000, rf_sel};
        bfs_pkg::OFF_RF_DATA: prdata <= {24'h00_0000, rf[rf_sel]};
        bfs_pkg::OFF_IO_SEL: prdata <= {{(32-IOW){1'b0}}, io_sel};
        bfs_pkg::OFF_IO_DATA: prdata <= {24'h00_0000, io_mem[io_sel]};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // command latch and sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= bfs_pkg::OP_NOP;
      bsel <= 3'h0;
      dst <= 5'h00;
      src <= 5'h00;
      imm <= 8'h00;
    end else if (wr_to(bfs_pkg::OFF_CMD)) begin
      op <= bfs_pkg::bfs_op_t'(pwdata[bfs_pkg::CMD_OP_LSB +: 6]);
      bsel <= pwdata[bfs_pkg::CMD_BIT_LSB +: 3];
      dst <= pwdata[bfs_pkg::CMD_DST_LSB +: 5];
      src <= pwdata[bfs_pkg::CMD_SRC_LSB +: 5];
      imm <= pwdata[bfs_pkg::CMD_IMM_LSB +: 8];
    end
  end

  logic take;
  logic io_op;
  assign io_op = (op == bfs_pkg::OP_IO_BIT_RAISE) || (op == bfs_pkg::OP_IO_BIT_DROP);

  always_comb begin
    take = 1'b0;
    if (op == bfs_pkg::OP_BRANCH_WHEN_IRQ_ON) begin
      take = status_flags_reg[bfs_pkg::FLG_I];
    end else if (op == bfs_pkg::OP_BRANCH_WHEN_IRQ_OFF) begin
      take = !status_flags_reg[bfs_pkg::FLG_I];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      bfs_pkg::ST_IDLE: begin
        if (wr_to(bfs_pkg::OFF_CMD)) begin
          next_state = bfs_pkg::ST_EXEC;
        end
      end
      bfs_pkg::ST_EXEC: next_state = (io_op || take) ? bfs_pkg::ST_SECOND : bfs_pkg::ST_IDLE;
      bfs_pkg::ST_SECOND: next_state = bfs_pkg::ST_IDLE;
      default: next_state = bfs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bfs_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  logic exec;
  logic second;
  assign exec = (state == bfs_pkg::ST_EXEC);
  assign second = (state == bfs_pkg::ST_SECOND);

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= bfs_pkg::PC_RST;
    end else if (exec) begin
      pc <= pc + 16'h0001;
    end else if (second && take) begin
      pc <= pc + {{9{imm[6]}}, imm[6:0]};
    end else if (wr_to(bfs_pkg::OFF_PC)) begin
      pc <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // shift unit
  // ----------------------------------------------------------------
  bfs_shift_if sh_bus ();

  always_comb begin
    unique case (op)
      bfs_pkg::OP_LOGIC_SHIFT_RIGHT: sh_bus.kind = bfs_pkg::SH_LOGIC_SHIFT_RIGHT;
      bfs_pkg::OP_ROTATE_LEFT_CARRY: sh_bus.kind = bfs_pkg::SH_ROTATE_LEFT_CARRY;
      bfs_pkg::OP_ROTATE_RIGHT_CARRY: sh_bus.kind = bfs_pkg::SH_ROTATE_RIGHT_CARRY;
      bfs_pkg::OP_ARITH_SHIFT_RIGHT: sh_bus.kind = bfs_pkg::SH_ARITH_SHIFT_RIGHT;
      default: sh_bus.kind = bfs_pkg::SH_LOGIC_SHIFT_LEFT;
    endcase
  end
  assign sh_bus.operand = rf[dst];
  assign sh_bus.carry_in = status_flags_reg[bfs_pkg::FLG_C];

  bfs_shift_unit u_shift (
    .sh(sh_bus.unit)
  );

  logic shift_op;
  assign shift_op = (op == bfs_pkg::OP_LOGIC_SHIFT_LEFT) || (op == bfs_pkg::OP_LOGIC_SHIFT_RIGHT)
    || (op == bfs_pkg::OP_ROTATE_LEFT_CARRY) || (op == bfs_pkg::OP_ROTATE_RIGHT_CARRY)
    || (op == bfs_pkg::OP_ARITH_SHIFT_RIGHT);

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_reg <= bfs_pkg::FLAGS_RST;
    end else if (exec) begin
      if (shift_op) begin
        status_flags_reg[bfs_pkg::FLG_Z] <= sh_bus.z_out;
        status_flags_reg[bfs_pkg::FLG_C] <= sh_bus.c_out;
        status_flags_reg[bfs_pkg::FLG_N] <= sh_bus.n_out;
        status_flags_reg[bfs_pkg::FLG_V] <= sh_bus.v_out;
      end else if (op == bfs_pkg::OP_FLAG_RAISE) begin
        status_flags_reg[bsel] <= 1'b1;
      end else if (op == bfs_pkg::OP_FLAG_DROP) begin
        status_flags_reg[bsel] <= 1'b0;
      end else if (op == bfs_pkg::OP_COPY_BIT_TO_TRANSFER_FLAG) begin
        status_flags_reg[bfs_pkg::FLG_T] <= rf[src][bsel];
      end
    end else if (wr_to(bfs_pkg::OFF_STATUS)) begin
      status_flags_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [4:0] dst_even;
  logic [4:0] src_even;
  assign dst_even = {dst[4:1], 1'b0};
  assign src_even = {src[4:1], 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++) begin
        rf[i] <= bfs_pkg::RF_RST;
      end
    end else if (exec) begin
      unique case (op)
        bfs_pkg::OP_LOGIC_SHIFT_LEFT, bfs_pkg::OP_ROTATE_LEFT_CARRY,
        bfs_pkg::OP_LOGIC_SHIFT_RIGHT, bfs_pkg::OP_ROTATE_RIGHT_CARRY,
        bfs_pkg::OP_ARITH_SHIFT_RIGHT: rf[dst] <= sh_bus.result;
        bfs_pkg::OP_NIBBLE_SWAP: rf[dst] <= {rf[dst][3:0], rf[dst][7:4]};
        bfs_pkg::OP_LOAD_BIT_FROM_TRANSFER: rf[dst][bsel] <= status_flags_reg[bfs_pkg::FLG_T];
        bfs_pkg::OP_COPY_REGISTER: rf[dst] <= rf[src];
        bfs_pkg::OP_COPY_REGISTER_PAIR: begin
          rf[dst_even] <= rf[src_even];
          rf[dst_even + 5'd1] <= rf[src_even + 5'd1];
        end
        bfs_pkg::OP_LOAD_IMMEDIATE: rf[dst] <= imm;
        default: begin
        end
      endcase
    end else if (wr_to(bfs_pkg::OFF_RF_DATA)) begin
      rf[rf_sel] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_sel <= 5'h00;
      io_sel <= '0;
    end else begin
      if (wr_to(bfs_pkg::OFF_RF_SEL)) begin
        rf_sel <= pwdata[4:0];
      end
      if (wr_to(bfs_pkg::OFF_IO_SEL)) begin
        io_sel <= pwdata[IOW-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // io registers
  // ----------------------------------------------------------------
  // addresses beyond the io bank are ignored rather than aliased
  logic io_hit;
  logic [IOW-1:0] io_addr;
  assign io_hit = (int'(imm) < IO_REGS);
  assign io_addr = imm[IOW-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < IO_REGS; i++) begin
        io_mem[i] <= bfs_pkg::IO_RST;
      end
    end else if (second && io_op) begin
      if (io_hit) begin
        io_mem[io_addr][bsel] <= (op == bfs_pkg::OP_IO_BIT_RAISE);
      end
    end else if (wr_to(bfs_pkg::OFF_IO_DATA)) begin
      io_mem[io_sel] <= pwdata[7:0];
    end
  end

  assign io_port0 = io_mem[0];
endmodule
`default_nettype wire

// ===== verification/bfs_exec_core_assertions.sv
// port checker for the execution core: stall lengths and io bit effects
`timescale 1ns/1ps
`default_nettype none
module bfs_exec_core_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] io_port0
);
  logic cmd_acc;
  logic [5:0] op;
  logic next_ok;
  // an access in flight must be answered once the core is free again
  assign cmd_acc = psel && penable && pwrite && pready && paddr == bfs_pkg::OFF_CMD;
  assign op = pwdata[5:0];
  assign next_ok = !(psel && penable) || pready;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  io_raise_a: assert property (
    cmd_acc && op == 6'h03 && pwdata[26:19] == 8'h00 |-> ##3
    io_port0 == ($past(io_port0, 3) | (8'h01 << $past(pwdata[8:6], 3))))
    else $error("io bit raise gave a wrong port value");
  io_drop_a: assert property (
    cmd_acc && op == 6'h04 && pwdata[26:19] == 8'h00 |-> ##1 $stable(io_port0) [*2] ##1
    io_port0 == ($past(io_port0, 3) & ~(8'h01 << $past(pwdata[8:6], 3))))
    else $error("io bit drop gave a wrong port value");
  io_op_wait_a: assert property (
    cmd_acc && (op == 6'h03 || op == 6'h04) |-> ##1 !pready [*3] ##1 next_ok)
    else $error("io bit op did not take two cycles");
  shift_wait_a: assert property (
    cmd_acc && op >= 6'h05 && op <= 6'h0A |=> !pready [*2] ##1 next_ok)
    else $error("shift op did not take one cycle");
  flag_wait_a: assert property (
    cmd_acc && (op == 6'h0B || op == 6'h0C) |=> !pready ##1 !pready ##1 next_ok)
    else $error("flag op did not take one cycle");
  bit_move_wait_a: assert property (
    cmd_acc && (op == 6'h0D || op == 6'h0E) |-> ##3 next_ok)
    else $error("bit transfer op was late");
  reg_move_wait_a: assert property (
    cmd_acc && op >= 6'h0F && op <= 6'h11 |=> !pready [*2] ##1 next_ok)
    else $error("register move op did not take one cycle");
  branch_wait_a: assert property (
    cmd_acc && (op == 6'h01 || op == 6'h02) |=> !pready [*2] ##2 next_ok)
    else $error("branch took more than two cycles");
endmodule

bind bfs_exec_core bfs_exec_core_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_port0(io_port0));
`default_nettype wire

// ===== verification/tb_bit_flag_shift_execution.sv
// self-checking bench for the bit, flag and shift execution core
`timescale 1ns/1ps
`default_nettype none
module tb_bit_flag_shift_execution;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] io_port0;
  logic [31:0] rd;
  logic err;
  int waits;
  int mismatches = 0;
  int checks = 0;

  always #2 pclk = ~pclk;

  bfs_exec_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_port0(io_port0));

  // ------
  // bus and compare helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // waits counts access cycles spent stalled; an idle gap follows each transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      waits++;
      if (waits > 40) begin
        $display("MISMATCH at %0t: no pready", $time);
        mismatches++;
        stop_test();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic setr(input logic [4:0] r, input logic [7:0] v);
    wr(bfs_pkg::OFF_RF_SEL, {27'h0, r});
    wr(bfs_pkg::OFF_RF_DATA, {24'h0, v});
  endtask

  task automatic rchk(input logic [4:0] r, input logic [7:0] exp);
    wr(bfs_pkg::OFF_RF_SEL, {27'h0, r});
    rdc(bfs_pkg::OFF_RF_DATA, {24'h0, exp});
  endtask

  task automatic exec(input logic [5:0] op, input logic [2:0] b, input logic [4:0] d,
                      input logic [4:0] s, input logic [7:0] imm);
    wr(bfs_pkg::OFF_CMD, {5'h00, imm, s, d, b, op});
  endtask

  // returns {carry out, result}
  function automatic logic [8:0] shx(input logic [5:0] op, input logic [7:0] v,
                                     input logic c);
    case (op)
      6'h05: return {v[7], v[6:0], 1'b0};
      6'h06: return {v[0], 1'b0, v[7:1]};
      6'h07: return {v[7], v[6:0], c};
      6'h08: return {v[0], c, v[7:1]};
      default: return {v[0], v[7], v[7:1]};
    endcase
  endfunction

  // ------
  // scenarios
  // ------
  task automatic t_reset;
    rdc(bfs_pkg::OFF_STATUS, 32'h0000_0000);
    rdc(bfs_pkg::OFF_PC, 32'h0000_0000);
    chk(io_port0, 8'h00);
    rdc(8'h40, 32'h0000_0000);
    chk(err, 1'b1);
    $display("reset test done");
  endtask

  // both branch kinds with the flag on and off, forward and backward offsets
  task automatic t_branch;
    logic tk;
    for (int i = 0; i < 4; i++) begin
      tk = i[0] == i[1];
      wr(bfs_pkg::OFF_STATUS, {24'h0, i[0], 7'h2A});
      wr(bfs_pkg::OFF_PC, 32'h0000_0040);
      exec(i[1] ? 6'h01 : 6'h02, 3'h0, 5'h00, 5'h00, i[1] ? 8'h7D : 8'h05);
      rdc(bfs_pkg::OFF_PC, tk ? (i[1] ? 32'h3E : 32'h46) : 32'h41);
      chk(waits, tk);
      rdc(bfs_pkg::OFF_STATUS, {24'h0, i[0], 7'h2A});
    end
    $display("branch test done");
  endtask

  task automatic t_io;
    wr(bfs_pkg::OFF_STATUS, 32'h5A);
    wr(bfs_pkg::OFF_IO_SEL, 32'h0);
    wr(bfs_pkg::OFF_IO_DATA, 32'h0F);
    exec(6'h03, 3'h7, 5'h00, 5'h00, 8'h00);
    rdc(bfs_pkg::OFF_STATUS, 32'h5A);
    chk(waits, 1);
    chk(io_port0, 8'h8F);
    exec(6'h04, 3'h0, 5'h00, 5'h00, 8'h00);
    rdc(bfs_pkg::OFF_IO_DATA, 32'h8E);
    chk(waits, 1);
    wr(bfs_pkg::OFF_IO_SEL, 32'h5);
    exec(6'h03, 3'h2, 5'h00, 5'h00, 8'h05);
    rdc(bfs_pkg::OFF_IO_DATA, 32'h04);
    chk(io_port0, 8'h8E);
    rdc(bfs_pkg::OFF_STATUS, 32'h5A);
    $display("io bit test done");
  endtask

  // every shift kind, once with a carry and sign in play, once from 01, ending at zero for the right shifts
  task automatic t_shift;
    logic [8:0] e;
    logic [7:0] v;
    logic [5:0] op;
    for (int i = 0; i < 10; i++) begin
      op = 6'h05 + 6'(i / 2);
      v = i[0] ? 8'h81 : 8'h01;
      e = shx(op, v, i[0]);
      setr(5'h03, v);
      wr(bfs_pkg::OFF_STATUS, {24'h0, 7'h1F, i[0]});
      exec(op, 3'h0, 5'h03, 5'h00, 8'h00);
      rchk(5'h03, e[7:0]);
      // i and t stay clear, h and s stay set from the status write above
      rdc(bfs_pkg::OFF_STATUS,
          {24'h00_0000, 4'h3, e[7] ^ e[8], e[7], e[7:0] == 8'h00, e[8]});
    end
    $display("shift test done");
  endtask

  task automatic t_flags;
    for (int b = 0; b < 8; b++) begin
      wr(bfs_pkg::OFF_STATUS, 32'h00);
      exec(6'h0B, 3'(b), 5'h00, 5'h00, 8'h00);
      rdc(bfs_pkg::OFF_STATUS, 32'h1 << b);
      chk(waits, 0);
      wr(bfs_pkg::OFF_STATUS, 32'hFF);
      exec(6'h0C, 3'(b), 5'h00, 5'h00, 8'h00);
      rdc(bfs_pkg::OFF_STATUS, 32'hFF ^ (32'h1 << b));
    end
    $display("flag test done");
  endtask

  task automatic t_bits;
    setr(5'h04, 8'hDF);
    wr(bfs_pkg::OFF_STATUS, 32'hFF);
    exec(6'h0D, 3'h5, 5'h00, 5'h04, 8'h00);
    rdc(bfs_pkg::OFF_STATUS, 32'hBF);
    setr(5'h05, 8'h00);
    wr(bfs_pkg::OFF_STATUS, 32'h40);
    exec(6'h0E, 3'h2, 5'h05, 5'h00, 8'h00);
    rchk(5'h05, 8'h04);
    rdc(bfs_pkg::OFF_STATUS, 32'h40);
    $display("bit transfer test done");
  endtask

  task automatic t_moves;
    wr(bfs_pkg::OFF_STATUS, 32'hC3);
    setr(5'h06, 8'hA5);
    setr(5'h08, 8'h11);
    setr(5'h09, 8'h22);
    exec(6'h0F, 3'h0, 5'h07, 5'h06, 8'h00);
    exec(6'h10, 3'h0, 5'h0A, 5'h08, 8'h00);
    exec(6'h11, 3'h0, 5'h0C, 5'h00, 8'h3C);
    exec(6'h0A, 3'h0, 5'h06, 5'h00, 8'h00);
    rchk(5'h07, 8'hA5);
    rchk(5'h0A, 8'h11);
    rchk(5'h0B, 8'h22);
    rchk(5'h0C, 8'h3C);
    rchk(5'h06, 8'h5A);
    rdc(bfs_pkg::OFF_STATUS, 32'hC3);
    $display("move test done");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_branch();
    t_io();
    t_shift();
    t_flags();
    t_bits();
    t_moves();
    stop_test();
  end
endmodule
`default_nettype wire
